// ===== serial_channel_pkg.sv
/*
  constants of the serial channel: register map, control and status
  fields, frame modes and sampling points.
  assumes a 32-bit apb master and a 50 MHz pclk.
*/
package serial_channel_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_TXB = 8'h0C;
  localparam logic [7:0] ADDR_RXB = 8'h10;
  localparam logic [7:0] ADDR_PMW = 8'h14;
  // control register fields
  localparam int C_STP = 3;
  localparam int C_PEN = 4;
  localparam int C_OEN = 5;
  localparam int C_ODD = 6;
  localparam int C_LB = 7;
  localparam int C_RUN = 8;
  localparam int C_REN = 9;
  localparam int C_RXI = 10;
  localparam int C_PRE = 11;
  // status register fields
  localparam int S_PE = 0;
  localparam int S_FE = 1;
  localparam int S_OE = 2;
  localparam int IR_WIDTH_MODE_BIT = 8;
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [12:0] BAUD_RST = 13'h0000;
  localparam logic [8:0] PMW_RST = 9'h000;
  // frame modes
  localparam logic [2:0] M_8D = 3'h1;
  localparam logic [2:0] M_IR = 3'h2;
  localparam logic [2:0] M_7P = 3'h3;
  localparam logic [2:0] M_9D = 3'h4;
  localparam logic [2:0] M_WU = 3'h5;
  localparam logic [2:0] M_8P = 3'h7;
  // sixteenth-of-bit positions
  localparam logic [3:0] SMP7 = 4'h6;
  localparam logic [3:0] SMP8 = 4'h7;
  localparam logic [3:0] SMP9 = 4'h8;
  localparam logic [3:0] PH_LAST = 4'hF;
  localparam logic [3:0] IR_FROM = 4'h8;
  localparam logic [3:0] IR_TO = 4'hA;
  localparam logic [4:0] IR_HOLD = 5'h10;
endpackage : serial_channel_pkg

// ===== serial_channel.sv
/*
  asynchronous serial channel with infrared framing and an apb slave.
  assumes rxd synchronous to pclk and a well-behaved apb master.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  output logic tx_buffer_empty_request,
  output logic tx_done_request,
  output logic rx_done_request,
  output logic error_request_line
);
  typedef enum logic {RX_IDLE, RX_BIT} rx_state_t;

  logic [11:0] ctrl_r;
  logic [12:0] baud_r;
  logic [8:0] pmw_r;
  logic [8:0] tx_holding_buffer;
  logic tbuf_full_r;
  logic [8:0] rx_holding_buffer;
  logic rx_buffer_bits_full_r;
  logic pe_r, fe_r, oe_r;
  logic [31:0] prdata_r;
  logic tbe_r, tdone_r, rdone_r, err_r, txd_r;

  // ***************************
  // register access
  // ***************************
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_ctrl = paddr == serial_channel_pkg::ADDR_CTRL;
  wire hit_stat = paddr == serial_channel_pkg::ADDR_STAT;
  wire hit_baud = paddr == serial_channel_pkg::ADDR_BAUD;
  wire hit_txb = paddr == serial_channel_pkg::ADDR_TXB;
  wire hit_rxb = paddr == serial_channel_pkg::ADDR_RXB;
  wire hit_pmw = paddr == serial_channel_pkg::ADDR_PMW;
  wire hit = hit_ctrl | hit_stat | hit_baud | hit_txb | hit_rxb | hit_pmw;
  wire txb_wr = wr & hit_txb;
  wire rxb_rd = rd & hit_rxb;
  wire stat_wr = wr & hit_stat;
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata = prdata_r;

  // ***************************
  // mode decode
  // ***************************
  // one format for both directions
  wire [2:0] mode = ctrl_r[2:0];
  wire run = ctrl_r[serial_channel_pkg::C_RUN];
  wire odd = ctrl_r[serial_channel_pkg::C_ODD];
  wire irda = mode == serial_channel_pkg::M_IR;
  wire m7p = mode == serial_channel_pkg::M_7P;
  wire m8p = mode == serial_channel_pkg::M_8P;
  wire mwu = mode == serial_channel_pkg::M_WU;
  wire dl9 = mwu | m8p | (mode == serial_channel_pkg::M_9D);
  // infrared frames keep one stop bit
  wire ns2 = ctrl_r[serial_channel_pkg::C_STP] & ~irda;
  // check forced off outside parity modes
  wire par_en = (m7p | m8p) & ctrl_r[serial_channel_pkg::C_PEN];
  wire [3:0] dbits = dl9 ? 4'h9 : 4'h8;
  wire [3:0] total = dbits + (ns2 ? 4'h3 : 4'h2);
  wire [3:0] stop1 = ns2 ? 4'h3 : 4'h2;

  // ***************************
  // baud generator
  // ***************************
  logic [12:0] bcnt_r;
  logic pre_r;
  wire div_en = ~ctrl_r[serial_channel_pkg::C_PRE] | pre_r;
  // sixteen ticks per bit, none while stopped
  wire tick = run & div_en & (bcnt_r == 13'h0000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_r <= 13'h0000;
      pre_r <= 1'b0;
    end else begin
      pre_r <= ~pre_r;
      if (!run || tick) begin
        bcnt_r <= baud_r;
      end else if (div_en) begin
        bcnt_r <= bcnt_r - 13'h0001;
      end
    end
  end

  // ***************************
  // transmitter
  // ***************************
  logic [3:0] tx_ph_r;
  logic tx_load_r, tx_send_r;
  logic [11:0] tx_sh_r;
  logic [3:0] tx_cnt_r;
  logic [7:0] ir_cnt_r;
  wire [8:0] tb = tx_holding_buffer;
  // parity is data xor, inverted for odd
  wire p7 = ^tb[6:0] ^ odd;
  wire p8 = ^tb[7:0] ^ odd;
  wire [8:0] field = m7p ? {1'b1, p7, tb[6:0]} :
                     m8p ? {p8, tb[7:0]} :
                     dl9 ? tb : {1'b1, tb[7:0]};
  // start bit, field lsb first, stop bits
  wire [11:0] frame = {2'b11, field, 1'b0};
  // divide-by-16 overflow
  wire bit_tick = tick & (tx_ph_r == serial_channel_pkg::PH_LAST);
  wire tx_last = tx_send_r & bit_tick & (tx_cnt_r == 4'h1);
  wire tx_take = tbuf_full_r & run &
                 ((~tx_load_r & ~tx_send_r) | tx_last);
  wire tx_line = tx_send_r ? tx_sh_r[0] : 1'b1;
  wire tx_done = tx_send_r & bit_tick & (tx_cnt_r == stop1);
  wire ir_start = tx_send_r & ~tx_sh_r[0] & tick &
                  (tx_ph_r == serial_channel_pkg::SMP8);
  wire ir_fix = tx_send_r & ~tx_sh_r[0] &
                (tx_ph_r >= serial_channel_pkg::IR_FROM) &
                (tx_ph_r <= serial_channel_pkg::IR_TO);
  wire irpw = pmw_r[serial_channel_pkg::IR_WIDTH_MODE_BIT];
  // 3/16 pulse or programmed width
  wire ir_pulse = irpw ? (ir_cnt_r != 8'h00) : ir_fix;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ph_r <= 4'h0;
      tx_load_r <= 1'b0;
      tx_send_r <= 1'b0;
      tx_sh_r <= 12'hFFF;
      tx_cnt_r <= 4'h0;
      ir_cnt_r <= 8'h00;
    end else begin
      if (tick) begin
        tx_ph_r <= tx_ph_r + 4'h1;
      end
      if (tx_take) begin
        tx_sh_r <= frame;
        tx_cnt_r <= total;
        tx_load_r <= ~tx_send_r;
      end else if (tx_load_r && bit_tick) begin
        tx_load_r <= 1'b0;
        tx_send_r <= 1'b1;
      end else if (tx_last) begin
        tx_send_r <= 1'b0;
      end else if (tx_send_r && bit_tick) begin
        tx_sh_r <= {1'b1, tx_sh_r[11:1]};
        tx_cnt_r <= tx_cnt_r - 4'h1;
      end
      if (ir_start) begin
        ir_cnt_r <= pmw_r[7:0];
      end else if (ir_cnt_r != 8'h00) begin
        ir_cnt_r <= ir_cnt_r - 8'h01;
      end
    end
  end

  // ***************************
  // receiver
  // ***************************
  rx_state_t rx_st_r;
  logic rx_prev_r, ir_prev_r, s7_r, s8_r, rx_fe_r;
  logic [4:0] ir_hold_r;
  logic [3:0] rx_sc_r, rx_idx_r;
  logic [8:0] rx_sh_r;
  wire ir_in = rxd ^ ctrl_r[serial_channel_pkg::C_RXI];
  wire ir_line = ir_hold_r == 5'h00;
  wire rx_src = ctrl_r[serial_channel_pkg::C_LB] ? tx_line :
                irda ? ir_line : rxd;
  wire rx_go = (rx_st_r == RX_IDLE) & rx_prev_r & ~rx_src & run &
               ctrl_r[serial_channel_pkg::C_REN];
  wire vote_now = (rx_st_r == RX_BIT) & tick &
                  (rx_sc_r == serial_channel_pkg::SMP9);
  wire vote = (s7_r & s8_r) | (s7_r & rx_src) | (s8_r & rx_src);
  wire rx_fin = vote_now & (rx_idx_r == total - 4'h1);
  wire [8:0] rx_dat = dl9 ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
  wire bad_par = (dl9 ? ^rx_dat : ^rx_dat[7:0]) ^ odd;
  wire accept = rx_fin & ~(mwu & ~rx_dat[8]);
  wire set_pe = accept & par_en & bad_par;
  wire set_fe = accept & (rx_fe_r | ~vote);
  wire set_oe = accept & rx_buffer_bits_full_r & ~rxb_rd &
                ctrl_r[serial_channel_pkg::C_OEN];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r <= RX_IDLE;
      rx_prev_r <= 1'b1;
      ir_prev_r <= 1'b1; // idle level, no false pulse after reset
      ir_hold_r <= 5'h00;
      s7_r <= 1'b1;
      s8_r <= 1'b1;
      rx_fe_r <= 1'b0;
      rx_sc_r <= 4'h0;
      rx_idx_r <= 4'h0;
      rx_sh_r <= 9'h000;
    end else begin
      rx_prev_r <= rx_src;
      ir_prev_r <= ir_in;
      // stretch a pulse into one low bit cell
      if (ir_in && !ir_prev_r) begin
        ir_hold_r <= serial_channel_pkg::IR_HOLD;
      end else if (tick && ir_hold_r != 5'h00) begin
        ir_hold_r <= ir_hold_r - 5'h01;
      end
      case (rx_st_r)
        RX_IDLE: begin
          if (rx_go) begin
            rx_st_r <= RX_BIT;
            rx_sc_r <= 4'h0;
            rx_idx_r <= 4'h0;
            rx_fe_r <= 1'b0;
          end
        end
        RX_BIT: begin
          if (tick) begin
            rx_sc_r <= rx_sc_r + 4'h1;
            if (rx_sc_r == serial_channel_pkg::PH_LAST) begin
              rx_idx_r <= rx_idx_r + 4'h1;
            end
            if (rx_sc_r == serial_channel_pkg::SMP7) begin
              s7_r <= rx_src;
            end
            if (rx_sc_r == serial_channel_pkg::SMP8) begin
              s8_r <= rx_src;
            end
          end
          if (vote_now) begin
            if (rx_idx_r == 4'h0) begin
              if (vote) begin
                rx_st_r <= RX_IDLE;
              end
            end else if (rx_idx_r <= dbits) begin
              rx_sh_r <= {vote, rx_sh_r[8:1]};
            end else begin
              rx_fe_r <= rx_fe_r | ~vote;
              if (rx_fin) begin
                rx_st_r <= RX_IDLE;
              end
            end
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // ***************************
  // registers and requests
  // ***************************
  wire [31:0] stat_v = {25'h0, rx_buffer_bits_full_r, rx_st_r == RX_BIT,
                        tx_send_r | tx_load_r, tbuf_full_r,
                        oe_r, fe_r, pe_r};
  wire [31:0] rd_mux =
    hit_ctrl ? {20'h0, ctrl_r} :
    hit_stat ? stat_v :
    hit_baud ? {19'h0, baud_r} :
    hit_rxb ? {23'h0, rx_holding_buffer} :
    hit_pmw ? {23'h0, pmw_r} : 32'h0;
  wire w1c_pe = stat_wr & pwdata[serial_channel_pkg::S_PE];
  wire w1c_fe = stat_wr & pwdata[serial_channel_pkg::S_FE];
  wire w1c_oe = stat_wr & pwdata[serial_channel_pkg::S_OE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= serial_channel_pkg::CTRL_RST;
      baud_r <= serial_channel_pkg::BAUD_RST;
      pmw_r <= serial_channel_pkg::PMW_RST;
      tx_holding_buffer <= 9'h000;
      tbuf_full_r <= 1'b0;
      rx_holding_buffer <= 9'h000;
      rx_buffer_bits_full_r <= 1'b0;
      pe_r <= 1'b0;
      fe_r <= 1'b0;
      oe_r <= 1'b0;
      prdata_r <= 32'h0;
      tbe_r <= 1'b0;
      tdone_r <= 1'b0;
      rdone_r <= 1'b0;
      err_r <= 1'b0;
      txd_r <= 1'b1;
    end else begin
      if (psel && !penable) begin
        prdata_r <= rd_mux;
      end
      if (wr && hit_ctrl) begin
        ctrl_r <= pwdata[11:0];
      end
      if (wr && hit_baud) begin
        baud_r <= pwdata[12:0];
      end
      if (wr && hit_pmw) begin
        pmw_r <= pwdata[8:0];
      end
      if (txb_wr) begin
        tx_holding_buffer <= pwdata[8:0];
      end
      tbuf_full_r <= txb_wr | (tbuf_full_r & ~tx_take);
      // only the receiver loads the buffer
      if (accept) begin
        rx_holding_buffer <= rx_dat;
      end
      rx_buffer_bits_full_r <= accept | (rx_buffer_bits_full_r & ~rxb_rd);
      pe_r <= set_pe | (pe_r & ~w1c_pe);
      fe_r <= set_fe | (fe_r & ~w1c_fe);
      oe_r <= set_oe | (oe_r & ~w1c_oe);
      tbe_r <= tx_take;
      tdone_r <= tx_done;
      rdone_r <= accept;
      err_r <= set_pe | set_fe | set_oe;
      txd_r <= irda ? ir_pulse : tx_line;
    end
  end

  assign txd = txd_r;
  assign tx_buffer_empty_request = tbe_r;
  assign tx_done_request = tdone_r;
  assign rx_done_request = rdone_r;
  assign error_request_line = err_r;

  // ***************************
  // assertions
  // ***************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  stop_no_take_a: assert property (!run |=> $stable(tx_sh_r))
    else $error("transmitter moved while stopped");
  take_frees_a: assert property (tx_take && !txb_wr |=>
    tbe_r && !tbuf_full_r)
    else $error("take did not free buffer");
  ren_gate_a: assert property ((rx_st_r == RX_IDLE) &&
    !ctrl_r[serial_channel_pkg::C_REN] |=> rx_st_r == RX_IDLE)
    else $error("receiver started while disabled");
  back_to_back_a: assert property (tx_last && tbuf_full_r |=>
    tx_send_r && !tx_sh_r[0])
    else $error("gap between frames");
  overrun_a: assert property (set_oe |=> oe_r && err_r &&
    rx_holding_buffer == $past(rx_dat))
    else $error("overrun not flagged");
  wake_drop_a: assert property (rx_fin && mwu && !rx_dat[8] |=>
    !rdone_r && $stable(rx_holding_buffer))
    else $error("wake-up frame not dropped");
  idle_high_a: assert property (!tx_send_r && !irda ##1 !irda |->
    txd_r)
    else $error("idle line not high");
  start_tick_a: assert property ($rose(tx_send_r) |->
    $past(bit_tick))
    else $error("frame started off an overflow");
  ir_zero_a: assert property (irda && !irpw ##1 txd_r |->
    $past(!tx_line, 2))
    else $error("pulse without a zero bit");
  done_early_a: assert property (tdone_r |-> tx_send_r &&
    tx_sh_r[0])
    else $error("done request outside stop bit");

  b2b_c: cover property (tx_last && tbuf_full_r);
  overrun_c: cover property (set_oe);
  wake_c: cover property (accept && mwu);
endmodule : serial_channel
`default_nettype wire

// ===== serial_peer.sv
/*
  remote serial peer: sends frames on rxd, captures frames from txd.
  assumes one bit lasts sixteen pclk cycles and the line idles high.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
  input wire logic pclk,
  input wire logic send,
  input wire logic [11:0] frame,
  input wire logic [3:0] nbits,
  input wire logic [3:0] rlen,
  input wire logic txd,
  output logic rxd,
  output logic busy,
  output logic [11:0] got,
  output logic got_done
);
  int i;
  int j;
  initial begin
    rxd = 1'b1;
    busy = 1'b0;
    got = 12'h000;
    got_done = 1'b0;
  end
  // ****************
  // sender
  // ****************
  // start bit, nbits bits lsb first, then back to idle high
  always begin
    @(posedge pclk);
    if (send === 1'b1) begin
      busy <= 1'b1;
      rxd <= 1'b0;
      repeat (16) @(posedge pclk);
      for (i = 0; i < nbits; i++) begin
        rxd <= frame[i];
        repeat (16) @(posedge pclk);
      end
      rxd <= 1'b1;
      busy <= 1'b0;
    end
  end
  // ****************
  // capture
  // ****************
  // mid-cell sample of rlen bits after the start edge; rlen 0 is off
  always begin
    @(negedge txd);
    if (rlen != 4'h0) begin
      got <= 12'h000;
      repeat (8) @(posedge pclk);
      for (j = 0; j < rlen; j++) begin
        repeat (16) @(posedge pclk);
        got[j] <= txd;
      end
      got_done <= 1'b1;
      @(posedge pclk);
      got_done <= 1'b0;
    end
  end
endmodule : serial_peer
`default_nettype wire

// ===== testbench.sv
/*
  self-checking bench of the serial channel over apb and serial pins.
  assumes baud reload 0 and divide by 1: a bit is sixteen pclk cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [31:0] STP2 = 32'h1 << serial_channel_pkg::C_STP;
  localparam logic [31:0] PEN = 32'h1 << serial_channel_pkg::C_PEN;
  localparam logic [31:0] OEN = 32'h1 << serial_channel_pkg::C_OEN;
  localparam logic [31:0] ODD = 32'h1 << serial_channel_pkg::C_ODD;
  localparam logic [31:0] LB = 32'h1 << serial_channel_pkg::C_LB;
  localparam logic [31:0] RUN = 32'h1 << serial_channel_pkg::C_RUN;
  localparam logic [31:0] REN = 32'h1 << serial_channel_pkg::C_REN;
  localparam logic [31:0] RXI = 32'h1 << serial_channel_pkg::C_RXI;
  localparam logic [31:0] PRE = 32'h1 << serial_channel_pkg::C_PRE;
  localparam logic [31:0] M8D = 32'(serial_channel_pkg::M_8D);
  localparam logic [31:0] M7P = 32'(serial_channel_pkg::M_7P);
  localparam logic [31:0] M8P = 32'(serial_channel_pkg::M_8P);
  localparam logic [31:0] M9D = 32'(serial_channel_pkg::M_9D);
  localparam logic [31:0] MWU = 32'(serial_channel_pkg::M_WU);
  localparam logic [31:0] MIR = 32'(serial_channel_pkg::M_IR);
  localparam logic [7:0] A_CTL = serial_channel_pkg::ADDR_CTRL;
  localparam logic [7:0] A_STA = serial_channel_pkg::ADDR_STAT;
  localparam logic [7:0] A_TXB = serial_channel_pkg::ADDR_TXB;
  localparam logic [7:0] A_RXB = serial_channel_pkg::ADDR_RXB;
  localparam logic [7:0] A_PMW = serial_channel_pkg::ADDR_PMW;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, send = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [11:0] frame = 12'h000, got;
  logic [3:0] nbits = 4'h0, rlen = 4'h0;
  logic pready, pslverr, rxd, txd, busy, got_done;
  logic tx_buffer_empty_request, tx_done_request, rx_done_request;
  logic error_request_line;
  int bad_count = 0, comparisons = 0, tbe_n = 0, tdn_n = 0, rdn_n = 0;
  int err_n = 0, pn = 0, pw = 0, hi = 0, cyc = 0;
  serial_channel u_serial_channel (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .txd,
    .tx_buffer_empty_request, .tx_done_request, .rx_done_request,
    .error_request_line);
  serial_peer u_serial_peer (.pclk, .send, .frame, .nbits, .rlen, .txd,
    .rxd, .busy, .got, .got_done);
  always #10 pclk = ~pclk;
  // ****************
  // pin monitors
  // ****************
  always @(posedge pclk) begin
    cyc++;
    if (tx_buffer_empty_request === 1'b1) tbe_n++;
    if (tx_done_request === 1'b1) tdn_n++;
    if (rx_done_request === 1'b1) rdn_n++;
    if (error_request_line === 1'b1) err_n++;
    if (txd === 1'b1) hi++;
    else if (hi != 0) begin
      pw = hi;
      pn++;
      hi = 0;
    end
  end
  // ****************
  // shared tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
      input string nm);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, x, q);
  endtask : rdc
  // status until the given bits read as v
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q;
    logic e;
    do apb(1'b0, A_STA, 32'h0, q, e); while ((q & m) !== v);
  endtask : poll
  task automatic rds(input logic [31:0] x);
    rdc(A_STA, x, "error flags");
  endtask : rds
  task automatic sendf(input logic [11:0] f, input logic [3:0] n);
    frame <= f;
    nbits <= n;
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    do @(posedge pclk); while (busy !== 1'b0);
    repeat (2) @(posedge pclk);
  endtask : sendf
  task automatic wait_got;
    do @(posedge pclk); while (got_done !== 1'b1);
  endtask : wait_got
  task automatic clr;
    tbe_n = 0;
    tdn_n = 0;
    rdn_n = 0;
    err_n = 0;
  endtask : clr
  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rdc(A_CTL, 32'h0, "ctrl reset");
    rdc(serial_channel_pkg::ADDR_BAUD, 32'h0, "baud reset");
    rdc(A_PMW, 32'h0, "pmw reset");
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped error", 32'h1, 32'(e));
    chk("ready", 32'h1, 32'(pready));
    chk("unmapped data", 32'h0, q);
    wr(A_RXB, 32'h1FF);
    rdc(A_RXB, 32'h0, "rx buffer write");
    $display("test registers done");
  endtask : t_regs
  task automatic t_tx;
    clr();
    rlen <= 4'h9;
    wr(A_CTL, M8D | REN);
    wr(A_TXB, 32'hFFA5);
    repeat (200) @(posedge pclk);
    chk("tbe while stopped", 32'h0, 32'(tbe_n));
    sendf({3'h0, 1'b1, 8'h5A}, 4'h9);
    chk("rx while stopped", 32'h0, 32'(rdn_n));
    wr(A_CTL, M8D | RUN);
    wait_got();
    chk("tx frame", 32'h1A5, 32'(got));
    chk("tbe pulses", 32'h1, 32'(tbe_n));
    chk("done before stop", 32'h1, 32'(tdn_n));
    poll(32'h18, 32'h0);
    $display("test transmit done");
  endtask : t_tx
  task automatic t_b2b;
    int c0;
    rlen <= 4'hA;
    wr(A_CTL, M8D | RUN | STP2);
    wr(A_TXB, 32'h11);
    wr(A_TXB, 32'h22);
    wait_got();
    c0 = cyc;
    wait_got();
    chk("frame spacing", 32'd176, 32'(cyc - c0));
    chk("second frame", 32'h322, 32'(got));
    poll(32'h18, 32'h0);
    $display("test back to back done");
  endtask : t_b2b
  task automatic t_par;
    logic [31:0] md [5];
    logic [8:0] d;
    logic [11:0] x;
    logic o;
    md = '{M7P, M7P | ODD, M8P, M8P | ODD, M9D};
    d = 9'h15B;
    for (int k = 0; k < 5; k++) begin
      o = k[0];
      if (k < 2) x = {3'h0, 1'b1, ^d[6:0] ^ o, d[6:0]};
      else if (k < 4) x = {2'h0, 1'b1, ^d[7:0] ^ o, d[7:0]};
      else x = {2'h0, 1'b1, d};
      rlen <= (k < 2) ? 4'h9 : 4'hA;
      wr(A_CTL, md[k] | RUN);
      wr(A_TXB, 32'(d));
      wait_got();
      chk("parity frame", 32'(x), 32'(got));
      poll(32'h18, 32'h0);
    end
    $display("test tx formats done");
  endtask : t_par
  task automatic t_rx;
    clr();
    rlen <= 4'h0;
    wr(A_CTL, M8P | RUN | REN | PEN);
    sendf({2'h0, 1'b1, ^8'hC3, 8'hC3}, 4'hA);
    rdc(A_RXB, 32'h0C3, "rx good parity");
    rds(32'h0);
    sendf({2'h0, 1'b1, ~^8'hC3, 8'hC3}, 4'hA);
    rdc(A_RXB, 32'h1C3, "rx bad parity");
    rds(32'h1);
    wr(A_STA, 32'h7);
    sendf({2'h0, 1'b0, ^8'hC3, 8'hC3}, 4'hA);
    rdc(A_RXB, 32'h0C3, "rx framing");
    rds(32'h2);
    wr(A_STA, 32'h7);
    wr(A_CTL, M9D | RUN | REN | PEN);
    sendf({2'h0, 1'b1, ~^8'hC3, 8'hC3}, 4'hA);
    rdc(A_RXB, 32'h1C3, "rx nine bits");
    rds(32'h0);
    wr(A_CTL, M7P | RUN | REN | PEN);
    sendf({3'h0, 1'b1, ^7'h43, 7'h43}, 4'h9);
    rdc(A_RXB, 32'h0C3, "rx seven parity");
    wr(A_CTL, M8D | RUN);
    sendf({3'h0, 1'b1, 8'h66}, 4'h9);
    chk("rx requests", 32'h5, 32'(rdn_n));
    chk("error requests", 32'h2, 32'(err_n));
    $display("test receive done");
  endtask : t_rx
  task automatic t_ovr;
    wr(A_CTL, M8D | RUN | REN | OEN);
    clr();
    sendf({3'h0, 1'b1, 8'h11}, 4'h9);
    sendf({3'h0, 1'b1, 8'h22}, 4'h9);
    rdc(A_RXB, 32'h22, "overrun data");
    rds(32'h4);
    chk("overrun request", 32'h1, 32'(err_n));
    wr(A_STA, 32'h7);
    $display("test overrun done");
  endtask : t_ovr
  task automatic t_wake;
    wr(A_CTL, MWU | RUN | REN);
    clr();
    sendf({2'h0, 2'h2, 8'h77}, 4'hA);
    chk("wake bit clear", 32'h0, 32'(rdn_n));
    sendf({2'h0, 2'h3, 8'h77}, 4'hA);
    chk("wake bit set", 32'h1, 32'(rdn_n));
    rdc(A_RXB, 32'h177, "wake data");
    $display("test wake-up done");
  endtask : t_wake
  task automatic t_loop;
    rlen <= 4'h0;
    wr(A_CTL, M8D | RUN | REN | LB);
    wr(A_TXB, 32'h3C);
    poll(32'h40, 32'h40);
    rdc(A_RXB, 32'h3C, "loop-back data");
    poll(32'h18, 32'h0);
    $display("test loop-back done");
  endtask : t_loop
  // reload 1 and divide by 2: a tick every 4 cycles, a bit 64 cycles
  task automatic t_baud;
    int n;
    wr(serial_channel_pkg::ADDR_BAUD, 32'h1);
    wr(A_CTL, M8D | RUN | PRE);
    wr(A_TXB, 32'h0F);
    wr(A_TXB, 32'hF0);
    do @(posedge pclk); while (tx_done_request !== 1'b1);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tx_done_request !== 1'b1);
    chk("bit timer", 32'd640, 32'(n));
    poll(32'h18, 32'h0);
    wr(serial_channel_pkg::ADDR_BAUD, 32'h0);
    $display("test baud timer done");
  endtask : t_baud
  task automatic t_ir;
    int c;
    wr(A_CTL, MIR | RUN);
    wr(A_PMW, 32'h0);
    c = pn;
    wr(A_TXB, 32'hFE);
    poll(32'h18, 32'h0);
    chk("ir pulses", 32'h2, 32'(pn - c));
    chk("ir width", 32'h3, 32'(pw));
    wr(A_PMW, 32'h105);
    c = pn;
    wr(A_TXB, 32'hFF);
    poll(32'h18, 32'h0);
    chk("ir ones", 32'h1, 32'(pn - c));
    chk("ir set width", 32'h5, 32'(pw));
    // inverted input: each lone low cell reads as one received pulse
    wr(A_CTL, MIR | RUN | REN | RXI);
    sendf({3'h0, 1'b1, 8'h55}, 4'h9);
    rdc(A_RXB, 32'h55, "ir receive");
    $display("test infrared done");
  endtask : t_ir
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_tx();
    t_b2b();
    t_par();
    t_rx();
    t_ovr();
    t_wake();
    t_loop();
    t_baud();
    t_ir();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
